// ### src/ers_seq.sv
// enclave resume sequencer with axi4-lite register access
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ers_seq (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // protected page metadata lookup
  output logic             pg_req,
  output logic [31:0]      pg_addr,
  output logic             pg_shadow,
  input  wire logic        pg_ack,
  input  wire logic        pg_in_epc,
  input  wire logic        pg_valid,
  input  wire logic        pg_blocked,
  input  wire logic        pg_pending,
  input  wire logic        pg_modified,
  input  wire logic        pg_addr_match,
  input  wire logic        pg_regular,
  input  wire logic        pg_shadow_type,
  input  wire logic        pg_same_encl,
  input  wire logic        pg_read,
  input  wire logic        pg_write,
  // saved register area and flow save area contents
  input  wire logic [63:0] gpr_rip,
  input  wire logic [63:0] gpr_fsbase,
  input  wire logic [63:0] gpr_gsbase,
  input  wire logic [31:0] gpr_rflags,
  input  wire logic [63:0] flow_stack_ptr,
  input  wire logic        flow_wait_branch,
  input  wire logic        flow_suppress,
  input  wire logic        flow_rsvd_nz,
  // extended state restore
  output logic             xr_req,
  output logic [31:0]      xr_frame,
  output logic [31:0]      xr_mask,
  input  wire logic        xr_ack,
  input  wire logic        xr_fault,
  // resulting core state
  output logic             encl_mode,
  output logic [31:0]      rng_base,
  output logic [31:0]      rng_size,
  output logic             save_seg,
  output logic [63:0]      fs_base,
  output logic [63:0]      gs_base,
  output logic [31:0]      fs_limit,
  output logic [31:0]      gs_limit,
  output logic [15:0]      tls_sel,
  output logic [3:0]       tls_type,
  output logic             bp_out_sup,
  output logic             bp_in_sup,
  output logic             mtrap_sup,
  output logic             saved_tf,
  output logic             clr_dbg
);
  ers_pkg::ers_state_e state_reg;
  logic [31:0] cfg_reg, fmask_reg, xcr_reg, fidx_reg, farea_reg, base_reg, fsize_reg;
  logic [31:0] xsize_reg, ofsb_reg, ogsb_reg, fslim_reg, gslim_reg, dslim_reg;
  logic [31:0] cslim_reg, ocet_reg, cetatr_reg, legoff_reg, size_reg;
  logic [31:0] faddr_reg, sxcr_reg, flags_reg, target_reg, frame_reg, page_reg;
  logic [3:0]  status_reg;
  logic        start_w, m64, pg_ok, flow_on, gp_now, wr_go;
  logic [31:0] gpr_la, fsb, gsb, fsl, gsl, flow_la, rd_next;

  function automatic logic canon(input logic [63:0] a);
    canon = (a[63:47] == {17{a[47]}});
  endfunction

  ////////////////////////////////////////////////////////////////
  // address arithmetic
  assign m64 = cfg_reg[ers_pkg::C_M64];
  assign flow_on = cetatr_reg[0] | cetatr_reg[1];
  assign gpr_la = frame_reg + (fsize_reg << ers_pkg::PAGE_SHIFT) - ers_pkg::GPR_SIZE;
  assign fsb = ofsb_reg + base_reg;
  assign gsb = ogsb_reg + base_reg;
  assign fsl = fsb + fslim_reg;
  assign gsl = gsb + gslim_reg;
  assign flow_la = ocet_reg + base_reg + ((fidx_reg - 32'h1) << ers_pkg::FLOW_SHIFT);
  assign pg_ok = pg_in_epc & pg_valid & ~pg_blocked & ~pg_pending & ~pg_modified
               & pg_addr_match & pg_same_encl & pg_read & pg_write
               & (pg_shadow ? pg_shadow_type : pg_regular);

  // segment, target, thread and flow attribute checks, in order
  always_comb begin
    gp_now = 1'b0;
    if (!m64 && (gpr_la + ers_pkg::GPR_SIZE - 32'h1) > dslim_reg) gp_now = 1'b1;
    else if (m64 && !canon(gpr_rip)) gp_now = 1'b1;
    else if (!m64 && gpr_rip > {32'h0, cslim_reg}) gp_now = 1'b1;
    else if (!m64 && (fsl < fsb ? dslim_reg != ers_pkg::LIMIT_4G : fsl > dslim_reg))
      gp_now = 1'b1;
    else if (!m64 && (gsl < gsb ? dslim_reg != ers_pkg::LIMIT_4G : gsl > dslim_reg))
      gp_now = 1'b1;
    else if (m64 && (!canon(gpr_fsbase) || !canon(gpr_gsbase))) gp_now = 1'b1;
    else if (cfg_reg[ers_pkg::C_ACTIVE]) gp_now = 1'b1;
    else if (cfg_reg[ers_pkg::C_LEAF] && !cfg_reg[ers_pkg::C_CR4CET]
             && (cetatr_reg != 32'h0 || legoff_reg != 32'h0)) gp_now = 1'b1;
    else if (cfg_reg[ers_pkg::C_LEAF] && flow_on && ocet_reg[3:0] != 4'h0)
      gp_now = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // sequencer
  assign pg_req = (state_reg == ers_pkg::ST_XPG) | (state_reg == ers_pkg::ST_GPR)
                | (state_reg == ers_pkg::ST_CPG);
  assign pg_shadow = (state_reg == ers_pkg::ST_CPG);
  assign pg_addr = (state_reg == ers_pkg::ST_GPR) ? (gpr_la & ers_pkg::PAGE_MASK)
                 : (state_reg == ers_pkg::ST_CPG) ? (flow_la & ers_pkg::PAGE_MASK) : page_reg;
  assign xr_req = (state_reg == ers_pkg::ST_XRS);
  assign xr_frame = frame_reg;
  assign xr_mask = fmask_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ers_pkg::ST_IDLE;
      status_reg <= 4'h0;
      frame_reg <= 32'h0;
      page_reg <= 32'h0;
      faddr_reg <= 32'h0;
    end else if (ce) begin
      case (state_reg)
        ers_pkg::ST_IDLE: begin
          if (start_w) begin
            state_reg <= ers_pkg::ST_CHK;
            status_reg <= 4'h1;
          end
        end
        ers_pkg::ST_CHK: begin
          frame_reg <= farea_reg + base_reg
                     + ((fsize_reg * (fidx_reg - 32'h1)) << ers_pkg::PAGE_SHIFT);
          page_reg <= farea_reg + base_reg
                    + ((fsize_reg * (fidx_reg - 32'h1)) << ers_pkg::PAGE_SHIFT);
          state_reg <= ers_pkg::ST_XPG;
          if (cfg_reg[ers_pkg::C_M64] != cfg_reg[ers_pkg::C_WIDE]
              || !cfg_reg[ers_pkg::C_FXSR]
              || (!cfg_reg[ers_pkg::C_XSAVE] && fmask_reg != ers_pkg::FMASK_LEGACY)
              || (cfg_reg[ers_pkg::C_XSAVE] && (fmask_reg & xcr_reg) != fmask_reg)
              || fidx_reg == 32'h0) begin
            state_reg <= ers_pkg::ST_IDLE;
            status_reg <= 4'h4;
          end
        end
        ers_pkg::ST_XPG: begin
          if (pg_ack) begin
            if (!pg_ok) begin
              state_reg <= ers_pkg::ST_IDLE;
              status_reg <= 4'h8;
              faddr_reg <= page_reg;
            end else if (page_reg + ers_pkg::PAGE_BYTES >= frame_reg + xsize_reg)
              state_reg <= ers_pkg::ST_GPR;
            page_reg <= page_reg + ers_pkg::PAGE_BYTES;
          end
        end
        ers_pkg::ST_GPR: begin
          if (pg_ack) begin
            state_reg <= ers_pkg::ST_SEG;
            if (!pg_ok) begin
              state_reg <= ers_pkg::ST_IDLE;
              status_reg <= 4'h8;
              faddr_reg <= gpr_la;
            end
          end
        end
        ers_pkg::ST_SEG: begin
          if (gp_now) begin
            state_reg <= ers_pkg::ST_IDLE;
            status_reg <= 4'h4;
          end else if (cfg_reg[ers_pkg::C_LEAF] && flow_on)
            state_reg <= ers_pkg::ST_CPG;
          else
            state_reg <= ers_pkg::ST_XRS;
        end
        ers_pkg::ST_CPG: begin
          if (pg_ack) begin
            state_reg <= ers_pkg::ST_CETV;
            if (!pg_ok) begin
              state_reg <= ers_pkg::ST_IDLE;
              status_reg <= 4'h8;
              faddr_reg <= flow_la & ers_pkg::PAGE_MASK;
            end
          end
        end
        ers_pkg::ST_CETV: begin
          state_reg <= ers_pkg::ST_XRS;
          if ((m64 && !canon(flow_stack_ptr)) || (!m64 && flow_stack_ptr[63:32] != 32'h0)
              || flow_stack_ptr[1:0] != 2'h0 || (flow_wait_branch && flow_suppress)
              || flow_rsvd_nz) begin
            state_reg <= ers_pkg::ST_IDLE;
            status_reg <= 4'h4;
          end
        end
        ers_pkg::ST_XRS: begin
          if (xr_ack) begin
            state_reg <= xr_fault ? ers_pkg::ST_IDLE : ers_pkg::ST_DONE;
            if (xr_fault) status_reg <= 4'h4;
          end
        end
        ers_pkg::ST_DONE: begin
          state_reg <= ers_pkg::ST_IDLE;
          status_reg <= 4'h2;
        end
        default: state_reg <= ers_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // commit of the resumed context
  assign save_seg = (state_reg == ers_pkg::ST_DONE);
  assign clr_dbg = (state_reg == ers_pkg::ST_DONE);
  assign rng_base = base_reg;
  assign rng_size = size_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      encl_mode <= 1'b0;
      fs_base <= 64'h0;
      gs_base <= 64'h0;
      fs_limit <= 32'h0;
      gs_limit <= 32'h0;
      tls_sel <= 16'h0;
      tls_type <= 4'h0;
      bp_out_sup <= 1'b0;
      bp_in_sup <= 1'b0;
      mtrap_sup <= 1'b0;
      saved_tf <= 1'b0;
      flags_reg <= ers_pkg::FLAG_FIXED;
      target_reg <= 32'h0;
      sxcr_reg <= 32'h0;
    end else if (ce && state_reg == ers_pkg::ST_DONE) begin
      encl_mode <= 1'b1;
      fs_base <= m64 ? gpr_fsbase : {32'h0, fsb};
      gs_base <= m64 ? gpr_gsbase : {32'h0, gsb};
      fs_limit <= fslim_reg;
      gs_limit <= gslim_reg;
      tls_sel <= ers_pkg::TLS_SEL;
      tls_type <= ers_pkg::TLS_TYPE;
      target_reg <= gpr_rip[31:0];
      bp_out_sup <= 1'b1;
      bp_in_sup <= ~cfg_reg[ers_pkg::C_DBGIN];
      mtrap_sup <= ~cfg_reg[ers_pkg::C_DBGIN];
      saved_tf <= cfg_reg[ers_pkg::C_DBGIN] ? saved_tf : cfg_reg[ers_pkg::C_TF];
      flags_reg <= (gpr_rflags & ers_pkg::FLAG_MASK) | ers_pkg::FLAG_FIXED
        | ({30'h0, cfg_reg[ers_pkg::C_IOPL +: 2]} << ers_pkg::IOPL_LO)
        | ({31'h0, (cfg_reg[ers_pkg::C_IOPL +: 2] == ers_pkg::IOPL_TOP)
            ? gpr_rflags[ers_pkg::IF_BIT] : cfg_reg[ers_pkg::C_IF]} << ers_pkg::IF_BIT)
        | ({31'h0, cfg_reg[ers_pkg::C_TF] & cfg_reg[ers_pkg::C_TRIN]
            & cfg_reg[ers_pkg::C_DBGIN]} << ers_pkg::TF_BIT);
      if (cfg_reg[ers_pkg::C_XSAVE]) sxcr_reg <= xcr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite slave
  assign wr_go = ce & s_awvalid & s_wvalid & ~s_bvalid;
  assign s_awready = wr_go;
  assign s_wready = wr_go;
  assign s_arready = ce & ~s_rvalid;
  assign start_w = wr_go && s_awaddr == ers_pkg::A_CTRL && s_wstrb[0] && s_wdata[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= 32'h0; fmask_reg <= 32'h0; xcr_reg <= 32'h0; fidx_reg <= 32'h0;
      farea_reg <= 32'h0; base_reg <= 32'h0; fsize_reg <= 32'h0; xsize_reg <= 32'h0;
      ofsb_reg <= 32'h0; ogsb_reg <= 32'h0; fslim_reg <= 32'h0; gslim_reg <= 32'h0;
      dslim_reg <= 32'h0; cslim_reg <= 32'h0; ocet_reg <= 32'h0; cetatr_reg <= 32'h0;
      legoff_reg <= 32'h0; size_reg <= 32'h0; xcr_reg <= 32'h0;
    end else if (ce) begin
      if (wr_go && state_reg == ers_pkg::ST_IDLE) begin
        case (s_awaddr)
          ers_pkg::A_CFG:    cfg_reg <= s_wdata;
          ers_pkg::A_FMASK:  fmask_reg <= s_wdata;
          ers_pkg::A_XCR:    xcr_reg <= s_wdata;
          ers_pkg::A_FIDX:   fidx_reg <= s_wdata;
          ers_pkg::A_FAREA:  farea_reg <= s_wdata;
          ers_pkg::A_BASE:   base_reg <= s_wdata;
          ers_pkg::A_FSIZE:  fsize_reg <= s_wdata;
          ers_pkg::A_XSIZE:  xsize_reg <= s_wdata;
          ers_pkg::A_OFSB:   ofsb_reg <= s_wdata;
          ers_pkg::A_OGSB:   ogsb_reg <= s_wdata;
          ers_pkg::A_FSLIM:  fslim_reg <= s_wdata;
          ers_pkg::A_GSLIM:  gslim_reg <= s_wdata;
          ers_pkg::A_DSLIM:  dslim_reg <= s_wdata;
          ers_pkg::A_CSLIM:  cslim_reg <= s_wdata;
          ers_pkg::A_OCET:   ocet_reg <= s_wdata;
          ers_pkg::A_CETATR: cetatr_reg <= s_wdata;
          ers_pkg::A_LEGOFF: legoff_reg <= s_wdata;
          ers_pkg::A_SIZE:   size_reg <= s_wdata;
          default: ;
        endcase
      end
      if (state_reg == ers_pkg::ST_XRS && xr_ack && xr_fault)
        cfg_reg[ers_pkg::C_ACTIVE] <= 1'b0;
      if (state_reg == ers_pkg::ST_DONE) begin
        fidx_reg <= fidx_reg - 32'h1;
        if (cfg_reg[ers_pkg::C_XSAVE]) xcr_reg <= fmask_reg;
      end
    end
  end

  always_comb begin
    case (s_araddr)
      ers_pkg::A_STATUS: rd_next = {28'h0, status_reg};
      ers_pkg::A_CFG:    rd_next = cfg_reg;
      ers_pkg::A_FMASK:  rd_next = fmask_reg;
      ers_pkg::A_XCR:    rd_next = xcr_reg;
      ers_pkg::A_FIDX:   rd_next = fidx_reg;
      ers_pkg::A_FAREA:  rd_next = farea_reg;
      ers_pkg::A_BASE:   rd_next = base_reg;
      ers_pkg::A_FSIZE:  rd_next = fsize_reg;
      ers_pkg::A_XSIZE:  rd_next = xsize_reg;
      ers_pkg::A_OFSB:   rd_next = ofsb_reg;
      ers_pkg::A_OGSB:   rd_next = ogsb_reg;
      ers_pkg::A_FSLIM:  rd_next = fslim_reg;
      ers_pkg::A_GSLIM:  rd_next = gslim_reg;
      ers_pkg::A_DSLIM:  rd_next = dslim_reg;
      ers_pkg::A_CSLIM:  rd_next = cslim_reg;
      ers_pkg::A_OCET:   rd_next = ocet_reg;
      ers_pkg::A_CETATR: rd_next = cetatr_reg;
      ers_pkg::A_LEGOFF: rd_next = legoff_reg;
      ers_pkg::A_SIZE:   rd_next = size_reg;
      ers_pkg::A_FADDR:  rd_next = faddr_reg;
      ers_pkg::A_SXCR:   rd_next = sxcr_reg;
      ers_pkg::A_FLAGS:  rd_next = flags_reg;
      ers_pkg::A_TARGET: rd_next = target_reg;
      default:           rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp <= ers_pkg::RESP_OK;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= ers_pkg::RESP_OK;
    end else if (ce) begin
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= (s_awaddr > ers_pkg::A_TARGET || s_awaddr[1:0] != 2'h0)
                   ? ers_pkg::RESP_ERR : ers_pkg::RESP_OK;
      end else if (s_bready) s_bvalid <= 1'b0;
      if (s_arvalid && !s_rvalid) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_next;
        s_rresp <= (s_araddr > ers_pkg::A_TARGET || s_araddr[1:0] != 2'h0)
                   ? ers_pkg::RESP_ERR : ers_pkg::RESP_OK;
      end else if (s_rready) s_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_mode_fault: assert property (ce && state_reg == ers_pkg::ST_CHK
    && !cfg_reg[ers_pkg::C_FXSR] |=> status_reg == 4'h4 && state_reg == ers_pkg::ST_IDLE)
    else $error("mode fault missed");
  chk_index_zero: assert property (ce && state_reg == ers_pkg::ST_CHK && fidx_reg == 32'h0
    |=> !pg_req) else $error("zero frame index went on");
  chk_page_fault: assert property (ce && pg_req && pg_ack && !pg_ok
    |=> status_reg[ers_pkg::S_PF] && faddr_reg[31:12] == $past(pg_addr[31:12]))
    else $error("page fault not reported");
  chk_active_thread: assert property (ce && state_reg == ers_pkg::ST_SEG
    && cfg_reg[ers_pkg::C_ACTIVE] |=> status_reg[ers_pkg::S_GP]) else $error("active thread ran");
  chk_restore_fault: assert property (ce && xr_req && xr_ack && xr_fault
    |=> !cfg_reg[ers_pkg::C_ACTIVE] && status_reg == 4'h4) else $error("restore fault lost");
  chk_index_pop: assert property (ce && state_reg == ers_pkg::ST_DONE
    |=> fidx_reg == $past(fidx_reg) - 32'h1 && encl_mode) else $error("index not popped");
  chk_tls_load: assert property (ce && save_seg
    |=> tls_sel == ers_pkg::TLS_SEL && tls_type == ers_pkg::TLS_TYPE) else $error("bad tls");
  chk_if_keep: assert property (ce && save_seg
    && cfg_reg[ers_pkg::C_IOPL +: 2] != ers_pkg::IOPL_TOP
    |=> flags_reg[ers_pkg::IF_BIT] == $past(cfg_reg[ers_pkg::C_IF])) else $error("if changed");
  chk_xcr_load: assert property (ce && save_seg && cfg_reg[ers_pkg::C_XSAVE]
    |=> xcr_reg == $past(fmask_reg) && sxcr_reg == $past(xcr_reg)) else $error("xcr not swapped");
endmodule

// ### src/ers_pkg.sv
// constants and types for the enclave resume sequencer
// Functional notes
// - gp fault when wide mode differs from enclave attribute or fp save disabled
// - mask must be 03h without extended save, else subset of control register
// - gp fault when current frame index is zero
// - frame address = area offset + base + 4096*size*(index-1)
// - every extended-state page must pass all protected page checks, else page fault
// - register area sits at frame end minus its size; its page is checked too
// - outside wide mode, register area last byte must lie in data segment
// - target from saved pointer; canonical in wide mode, else within code limit
// - outside wide mode, thread segments must fit the data limit, wrap needs 4GB
// - in wide mode thread bases come from register area and must be canonical
// - gp fault when the thread is already active
// - protection supported but disabled: attributes and bitmap offset must be zero
// - with stacks or branch tracking on, flow save offset must be 16B aligned
// - flow save area page must be a valid shadow restore page of this enclave
// - check restored stack pointer range and alignment, tracker and reserved fields
// - restore extended state; on its fault mark thread inactive and gp fault
// - enter enclave mode, record range, save thread segments
// - restore listed flags, clear vm, restore if only at privilege level 3
// - with extended save on, save control register and load the feature mask
// - decrement current frame index on success
// - load thread segments: base, limit, type 1, s g b p set, selector 0bh; no s g b p outputs here
// - suppress breakpoints, handle trap flag on opt-out, clear pending debug events
package ers_pkg;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CFG    = 8'h08;
  localparam logic [7:0] A_FMASK  = 8'h0c;
  localparam logic [7:0] A_XCR    = 8'h10;
  localparam logic [7:0] A_FIDX   = 8'h14;
  localparam logic [7:0] A_FAREA  = 8'h18;
  localparam logic [7:0] A_BASE   = 8'h1c;
  localparam logic [7:0] A_FSIZE  = 8'h20;
  localparam logic [7:0] A_XSIZE  = 8'h24;
  localparam logic [7:0] A_OFSB   = 8'h28;
  localparam logic [7:0] A_OGSB   = 8'h2c;
  localparam logic [7:0] A_FSLIM  = 8'h30;
  localparam logic [7:0] A_GSLIM  = 8'h34;
  localparam logic [7:0] A_DSLIM  = 8'h38;
  localparam logic [7:0] A_CSLIM  = 8'h3c;
  localparam logic [7:0] A_OCET   = 8'h40;
  localparam logic [7:0] A_CETATR = 8'h44;
  localparam logic [7:0] A_LEGOFF = 8'h48;
  localparam logic [7:0] A_SIZE   = 8'h4c;
  localparam logic [7:0] A_FADDR  = 8'h50;
  localparam logic [7:0] A_SXCR   = 8'h54;
  localparam logic [7:0] A_FLAGS  = 8'h58;
  localparam logic [7:0] A_TARGET = 8'h5c;
  // cfg bits
  localparam int C_M64 = 0;
  localparam int C_WIDE = 1;
  localparam int C_FXSR = 2;
  localparam int C_XSAVE = 3;
  localparam int C_LEAF = 4;
  localparam int C_CR4CET = 5;
  localparam int C_ACTIVE = 6;
  localparam int C_DBGIN = 7;
  localparam int C_TRIN = 8;
  localparam int C_IOPL = 9;
  localparam int C_TF = 11;
  localparam int C_IF = 12;
  // status bits
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_GP = 2;
  localparam int S_PF = 3;
  localparam logic [31:0] PAGE_BYTES = 32'h00001000;
  localparam logic [31:0] PAGE_MASK  = 32'hfffff000;
  localparam logic [31:0] GPR_SIZE   = 32'h000000b8;
  localparam logic [31:0] FMASK_LEGACY = 32'h00000003;
  localparam logic [31:0] LIMIT_4G   = 32'hffffffff;
  localparam logic [31:0] FLAG_MASK  = 32'h00254cd5;
  localparam logic [31:0] FLAG_FIXED = 32'h00000002;
  localparam int PAGE_SHIFT = 12;
  localparam int FLOW_SHIFT = 4;
  localparam int IF_BIT = 9;
  localparam int TF_BIT = 8;
  localparam int IOPL_LO = 12;
  localparam logic [1:0] IOPL_TOP = 2'h3;
  localparam logic [15:0] TLS_SEL = 16'h000b;
  localparam logic [3:0] TLS_TYPE = 4'h1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_CHK = 9'h002, ST_XPG = 9'h004, ST_GPR = 9'h008,
    ST_SEG = 9'h010, ST_CPG = 9'h020, ST_CETV = 9'h040, ST_XRS = 9'h080,
    ST_DONE = 9'h100
  } ers_state_e;
endpackage

// ### verification/ers_mem_model.sv
// page metadata lookup and extended restore partner
`timescale 1ns/1ps
module ers_mem_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // page lookup
  input  wire logic        pg_req,
  input  wire logic [31:0] pg_addr,
  input  wire logic [31:0] bad_page,
  output logic             pg_ack,
  output logic             pg_ok,
  // extended restore
  input  wire logic        xr_req,
  input  wire logic        xr_bad,
  output logic             xr_ack,
  output logic             xr_fault
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg_ack <= 1'b0;
      xr_ack <= 1'b0;
    end else begin
      pg_ack <= pg_req & !pg_ack;
      xr_ack <= xr_req & !xr_ack;
    end
  end
  // attributes are only meaningful with the ack, all bad otherwise
  assign pg_ok    = pg_ack & (pg_addr[31:12] !== bad_page[31:12]);
  assign xr_fault = xr_ack & xr_bad;
endmodule

// ### verification/ers_seq_tb_top.sv
// self-checking bench for the resume sequencer
`timescale 1ns/1ps
module ers_seq_tb_top;
  logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, xr_bad = 1'b0, s_awready, s_wready, s_bvalid, s_arready;
  logic s_rvalid, pg_req, pg_shadow, pg_ack, pg_ok, xr_req, xr_ack, xr_fault, encl_mode, save_seg;
  logic bp_out_sup, bp_in_sup, mtrap_sup, saved_tf, clr_dbg;
  logic flow_wait_branch = 1'b0, flow_suppress = 1'b0, flow_rsvd_nz = 1'b0;
  logic [1:0] s_bresp, s_rresp, rsp_q;
  logic [3:0] s_wstrb = 4'hf, tls_type;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [15:0] tls_sel;
  logic [31:0] s_wdata = 32'h0, bad_page = 32'h0, gpr_rflags = 32'hffffffff, s_rdata, rd_q;
  logic [31:0] pg_addr, xr_frame, xr_mask, rng_base, rng_size, fs_limit, gs_limit;
  logic [63:0] gpr_rip = 64'h12340, gpr_fsbase = 64'h0, gpr_gsbase = 64'h0, flow_stack_ptr = 64'h0;
  logic [63:0] fs_base, gs_base;
  wire pg_in_epc = pg_ok, pg_valid = pg_ok, pg_addr_match = pg_ok, pg_same_encl = pg_ok;
  wire pg_read = pg_ok, pg_write = pg_ok, pg_blocked = !pg_ok, pg_pending = !pg_ok;
  wire pg_modified = !pg_ok, pg_regular = pg_ok & !pg_shadow, pg_shadow_type = pg_ok & pg_shadow;
  // cfg .. size, written from 0x08 upward
  logic [31:0] cfg_v [18] = '{32'he0c, 32'h3, 32'h7, 32'h2, 32'h1000, 32'h10000, 32'h1, 32'h100,
    32'h2000, 32'h3000, 32'hfff, 32'hfff, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0, 32'h0,
    32'h10000};
  int num_errors = 0, n_tests = 0, i, k;
  ers_seq i_ers_seq (.*);
  ers_mem_model i_ers_mem_model (.*);
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for a handshake: 0 aw, 1 b, 2 ar, 3 r; answer taken at the negedge that sees it, before the handshake posedge
  task wt(input int s);
    i = 0;
    @(negedge mclk);
    while ((s == 0 ? s_awready : s == 1 ? s_bvalid : s == 2 ? s_arready : s_rvalid) !== 1'b1) begin
      if (++i > 300) begin
        num_errors++;
        finish_test();
      end
      @(negedge mclk);
    end
    rd_q = s_rdata;
    rsp_q = (s == 1) ? s_bresp : s_rresp;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    wt(0);
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    s_bready <= 1'b1;
    wt(1);
    s_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    wt(2);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    wt(3);
    s_rready <= 1'b0;
  endtask
  // full setup, one override, start, poll until not busy, judge status
  task run(input logic [7:0] a, input logic [31:0] d, input logic [31:0] st);
    for (k = 0; k < 18; k++) wr(ers_pkg::A_CFG + 8'(4 * k), cfg_v[k]);
    wr(a, d);
    wr(ers_pkg::A_CTRL, 32'h1);
    for (k = 0; k < 100; k++) begin
      rd(ers_pkg::A_STATUS);
      if (rd_q[0] === 1'b0) break;
    end
    chk(rd_q, st);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(ers_pkg::A_FLAGS);
    chk(rd_q, 32'h2);
    rd(8'h60);
    chk(rsp_q, ers_pkg::RESP_ERR);
    run(ers_pkg::A_LEGOFF, 32'h0, 32'h2);
    rd(ers_pkg::A_FIDX);
    chk(rd_q, 32'h1);
    rd(ers_pkg::A_FLAGS);
    chk(rd_q, 32'h257ed7);
    rd(ers_pkg::A_TARGET);
    chk(rd_q, 32'h12340);
    rd(ers_pkg::A_SXCR);
    chk(rd_q, 32'h7);
    rd(ers_pkg::A_XCR);
    chk(rd_q, 32'h3);
    chk({xr_frame, xr_mask}, 64'h12000_00000003);
    chk({encl_mode, rng_base}, 33'h1_00010000);
    chk({fs_base[31:0], gs_base[31:0]}, 64'h12000_00013000);
    chk({fs_limit, tls_sel, tls_type}, 52'hfff_000b_1);
    chk({bp_out_sup, bp_in_sup, mtrap_sup, saved_tf}, 4'hf);
    run(ers_pkg::A_CFG, 32'he08, 32'h4);
    run(ers_pkg::A_CFG, 32'he0e, 32'h4);
    run(ers_pkg::A_FMASK, 32'hf, 32'h4);
    run(ers_pkg::A_FIDX, 32'h0, 32'h4);
    run(ers_pkg::A_CSLIM, 32'h100, 32'h4);
    run(ers_pkg::A_DSLIM, 32'h12fff, 32'h4);
    run(ers_pkg::A_CFG, 32'he4c, 32'h4);
    rd(ers_pkg::A_FIDX);
    chk(rd_q, 32'h2);
    bad_page <= 32'h12000;
    run(ers_pkg::A_LEGOFF, 32'h0, 32'h8);
    rd(ers_pkg::A_FADDR);
    chk(rd_q, 32'h12000);
    bad_page <= 32'h0;
    xr_bad <= 1'b1;
    run(ers_pkg::A_LEGOFF, 32'h0, 32'h4);
    xr_bad <= 1'b0;
    // low privilege level keeps the current interrupt flag, opt-in keeps trap
    run(ers_pkg::A_CFG, 32'h98c, 32'h2);
    rd(ers_pkg::A_FLAGS);
    chk(rd_q, 32'h254dd7);
    chk({bp_out_sup, bp_in_sup, mtrap_sup, saved_tf}, 4'h9);
    chk(rng_size, 32'h10000);
    gpr_fsbase <= 64'h800000000000;
    run(ers_pkg::A_CFG, 32'he0f, 32'h4);
    gpr_fsbase <= 64'h0;
    cfg_v[0] = 32'he04;
    run(ers_pkg::A_FMASK, 32'h7, 32'h4);
    cfg_v[0] = 32'he1c;
    run(ers_pkg::A_LEGOFF, 32'h40, 32'h4);
    cfg_v[0] = 32'he3c;
    cfg_v[15] = 32'h1;
    run(ers_pkg::A_OCET, 32'h8, 32'h4);
    flow_stack_ptr <= 64'h2;
    run(ers_pkg::A_OCET, 32'h0, 32'h4);
    flow_stack_ptr <= 64'h0;
    bad_page <= 32'h10000;
    run(ers_pkg::A_OCET, 32'h0, 32'h8);
    rd(ers_pkg::A_FADDR);
    chk(rd_q, 32'h10000);
    bad_page <= 32'h0;
    run(ers_pkg::A_OCET, 32'h0, 32'h2);
    finish_test();
  end
endmodule
